// >>> rtl/ovmg_pkg.sv
package ovmg_pkg;
   // number of valve feedback monitors mapped onto the one output
   localparam int          NUM_MON        = 2;
   localparam int          CLK_HZ         = 100_000_000;
   // 1 ms tick from the 100 MHz clock
   localparam int          TICK_US        = 1000;
   localparam int          TICK_CYC       = CLK_HZ / 1_000_000 * TICK_US;
   localparam int          TICK_W         = 17;
   // valve-monitor timeout: base plus step * setting, all in ms
   localparam int          VMT_MIN_MS     = 100;
   localparam int          VMT_MAX_MS     = 5000;
   localparam int          VMT_STEP_MS    = 50;
   localparam int          VMT_SEL_W      = 7;
   localparam logic [6:0]  VMT_SEL_MAX    = 7'((VMT_MAX_MS - VMT_MIN_MS) / VMT_STEP_MS);
   localparam logic [6:0]  VMT_SEL_RST    = 7'h00;
   localparam int          MS_W           = 13;
   // off-delay length in ms
   localparam int          DLY_W          = 16;

   typedef enum logic [1:0] {
      OVMG_CANCEL_KEEP_ON  = 2'b00,
      OVMG_CANCEL_TURN_OFF = 2'b01,
      OVMG_CANCEL_CTRL_IN  = 2'b10
   } ovmg_cancel_t;

   typedef enum logic [1:0] {
      OVMG_ST_OFF     = 2'b00,
      OVMG_ST_ON      = 2'b01,
      OVMG_ST_DELAY   = 2'b10,
      OVMG_ST_LOCKOUT = 2'b11
   } ovmg_state_t;

   function automatic logic [MS_W-1:0] ovmg_timeout_ms(input logic [VMT_SEL_W-1:0] sel);
      logic [VMT_SEL_W-1:0] s;
      s = (sel > VMT_SEL_MAX) ? VMT_SEL_MAX : sel;
      return MS_W'(VMT_MIN_MS) + MS_W'(s) * MS_W'(VMT_STEP_MS);
   endfunction
endpackage

// >>> rtl/ovmg_valve_mon.sv
`timescale 1ns/1ps
module ovmg_valve_mon
   import ovmg_pkg::*;
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 srst,
   input  wire logic                 tick_ms,
   // configuration
   input  wire logic [VMT_SEL_W-1:0] timeout_sel,
   // output state and feedback
   input  wire logic                 out_on,
   input  wire logic                 feedback,
   // results
   output logic                      satisfied,
   output logic                      fault
);
   logic [MS_W-1:0] cnt;
   logic [MS_W-1:0] next_cnt;
   logic            running;
   logic            next_running;
   logic            out_on_d;
   logic            next_out_on_d;
   logic            next_fault;

   always_comb begin
      next_cnt      = cnt;
      next_running  = running;
      next_out_on_d = out_on;
      next_fault    = 1'b0;
      // [R01] timer on switch-off
      if (out_on_d && !out_on) begin
         next_running = 1'b1;
         next_cnt     = '0;
      end else if (running) begin
         if (feedback) begin
            next_running = 1'b0;
         end else if (tick_ms) begin
            next_cnt = MS_W'(cnt + 1'b1);
            if (next_cnt >= ovmg_timeout_ms(timeout_sel)) begin
               next_running = 1'b0;
               next_fault   = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt      <= '0;
         running  <= 1'b0;
         out_on_d <= 1'b0;
         fault    <= 1'b0;
      end else begin
         cnt      <= next_cnt;
         running  <= next_running;
         out_on_d <= next_out_on_d;
         fault    <= next_fault;
      end
   end

   // [R02] feedback high before turn-on
   // raw level: the timer flag clears a cycle late and would lock out a good valve
   assign satisfied = feedback;
endmodule

// >>> rtl/ovmg_gate.sv
`timescale 1ns/1ps
// Functional notes
// [R01] off starts monitor timer; late feedback locks out
// [R02] turn-on with low feedback locks out; with cfg_manual_reset low the code only holds the output off
// [R03] timeout 100 ms to 5 s, 50 ms steps
// [R04] every mapped monitor must be satisfied
// [R05] quick stop-run waits for feedback
// [R06] on/off command acts only when inputs run
// [R07] on/off command single channel, high runs
// [R08] unmapped on/off drives status output alone
// [R09] mute waits for mute enable run
// [R10] mute enable single channel level
// [R11] keep-on cancel holds delayed output on
// [R12] turn-off cancel drops output at once
// [R13] control-input return keeps output on
// [R14] delay-in-progress status while cancel effective
// [R15] manual reset holds off until reset
// [R16] non-monitored reset turns output on immediately
// [R17] lockout holds off until valid reset
module ovmg_gate
   import ovmg_pkg::*;
(
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         srst,
   // configuration
   input  wire logic [NUM_MON*VMT_SEL_W-1:0] cfg_timeout_sel,
   input  wire logic [NUM_MON-1:0]           cfg_mon_en,
   input  wire logic                         cfg_onoff_mapped,
   input  wire logic                         cfg_mute_en_used,
   input  wire logic                         cfg_manual_reset,
   input  wire logic [1:0]                   cfg_cancel_type,
   input  wire logic [DLY_W-1:0]             cfg_off_delay_ms,
   // field inputs
   input  wire logic                         safety_run,
   input  wire logic [NUM_MON-1:0]           valve_feedback_monitor,
   input  wire logic                         onoff_cmd,
   input  wire logic                         mute_enable,
   input  wire logic                         mute_request,
   input  wire logic                         reset_in,
   input  wire logic                         cancel_delay,
   // outputs
   output logic                              safety_out,
   output logic                              delay_in_progress,
   output logic                              onoff_status,
   output logic                              mute_active,
   output logic                              lockout
);
   ovmg_state_t         state;
   ovmg_state_t         next_state;
   logic [TICK_W-1:0]   div;
   logic [TICK_W-1:0]   next_div;
   logic                tick;
   logic                next_tick;
   logic [DLY_W-1:0]    dly;
   logic [DLY_W-1:0]    next_dly;
   logic                armed;
   logic                next_armed;
   logic                reset_d;
   logic                next_delay_ip;
   logic                next_onoff_st;
   logic                next_mute;
   logic                out_on;
   logic [NUM_MON-1:0]  mon_ok;
   logic [NUM_MON-1:0]  mon_fault;
   logic                all_ok;
   logic                any_fault;
   logic                run_ok;
   logic                reset_edge;

   always_comb begin
      next_tick = 1'b0;
      next_div  = TICK_W'(div + 1'b1);
      if (div == TICK_W'(TICK_CYC - 1)) begin
         next_div  = '0;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         div  <= '0;
         tick <= 1'b0;
      end else begin
         div  <= next_div;
         tick <= next_tick;
      end
   end

   // [R04] one monitor per feedback input, mapped or not; cfg_mon_en masks them below
   for (genvar i = 0; i < NUM_MON; i++) begin : g_mon
      ovmg_valve_mon u_mon (
         .clk         (clk),
         .srst        (srst),
         .tick_ms     (tick),
         // [R03] per-monitor timeout setting
         .timeout_sel (cfg_timeout_sel[i*VMT_SEL_W +: VMT_SEL_W]),
         .out_on      (out_on),
         .feedback    (valve_feedback_monitor[i]),
         .satisfied   (mon_ok[i]),
         .fault       (mon_fault[i])
      );
   end

   // [R04] all monitors enabled in cfg_mon_en must agree
   assign all_ok    = &(mon_ok | ~cfg_mon_en);
   assign any_fault = |(mon_fault & cfg_mon_en);
   // [R06] [R07] command qualifies run when mapped
   assign run_ok    = safety_run && (onoff_cmd || !cfg_onoff_mapped);
   assign reset_edge = reset_in && !reset_d;
   assign out_on    = (state == OVMG_ST_ON) || (state == OVMG_ST_DELAY);

   always_comb begin
      next_state    = state;
      next_dly      = dly;
      next_armed    = armed;
      next_delay_ip = 1'b0;
      unique case (state)
         OVMG_ST_OFF: begin
            // [R15] manual reset required after stop
            if (run_ok && (armed || (cfg_manual_reset && reset_in))) begin
               // [R02] [R05] feedback checked at turn-on
               if (!all_ok && !armed) begin
                  next_state = OVMG_ST_LOCKOUT;
               end else if (all_ok) begin
                  next_state = OVMG_ST_ON;
               end
            end
            if (!cfg_manual_reset) begin
               next_armed = 1'b1;
            end else if (!run_ok) begin
               next_armed = 1'b0;
            end else if (reset_in) begin
               // [R16] level reset turns on immediately
               next_armed = 1'b1;
            end
         end
         OVMG_ST_ON: begin
            if (!run_ok) begin
               next_armed = !cfg_manual_reset;
               next_dly   = cfg_off_delay_ms;
               next_state = (cfg_off_delay_ms == '0) ? OVMG_ST_OFF : OVMG_ST_DELAY;
            end
         end
         OVMG_ST_DELAY: begin
            next_delay_ip = 1'b1;
            if (tick) begin
               next_dly = DLY_W'(dly - 1'b1);
            end
            unique case (cfg_cancel_type)
               // [R11] cancel keeps output on
               OVMG_CANCEL_KEEP_ON: begin
                  if (cancel_delay) begin
                     next_state = OVMG_ST_ON;
                  end
               end
               // [R12] cancel drops output now
               OVMG_CANCEL_TURN_OFF: begin
                  if (cancel_delay) begin
                     next_state = OVMG_ST_OFF;
                  end
               end
               // [R13] input returns before end
               OVMG_CANCEL_CTRL_IN: begin
                  if (run_ok) begin
                     next_state = OVMG_ST_ON;
                  end
               end
               default: begin
               end
            endcase
            if (next_state == OVMG_ST_DELAY && tick && dly <= DLY_W'(1)) begin
               next_state = OVMG_ST_OFF;
            end
            if (next_state != OVMG_ST_DELAY) begin
               next_delay_ip = 1'b0;
            end
         end
         OVMG_ST_LOCKOUT: begin
            // [R17] only a reset with feedback good clears
            next_armed = 1'b0;
            if (reset_edge && all_ok) begin
               next_state = OVMG_ST_OFF;
            end
         end
      endcase
      // [R01] late feedback forces lockout
      if (any_fault) begin
         next_state    = OVMG_ST_LOCKOUT;
         next_delay_ip = 1'b0;
      end
   end

   // [R08] status follows command even if unmapped
   assign next_onoff_st = onoff_cmd;
   // [R09] [R10] mute gated by enable level
   assign next_mute = mute_request && (mute_enable || !cfg_mute_en_used);

   always_ff @(posedge clk) begin
      if (srst) begin
         state             <= OVMG_ST_OFF;
         dly               <= '0;
         armed             <= 1'b0;
         reset_d           <= 1'b0;
         safety_out        <= 1'b0;
         delay_in_progress <= 1'b0;
         onoff_status      <= 1'b0;
         mute_active       <= 1'b0;
         lockout           <= 1'b0;
      end else begin
         state             <= next_state;
         dly               <= next_dly;
         armed             <= next_armed;
         reset_d           <= reset_in;
         safety_out        <= (next_state == OVMG_ST_ON) || (next_state == OVMG_ST_DELAY);
         // [R14] status during cancel window
         delay_in_progress <= next_delay_ip;
         onoff_status      <= next_onoff_st;
         mute_active       <= next_mute;
         lockout           <= (next_state == OVMG_ST_LOCKOUT);
      end
   end
endmodule

// >>> tb/ovmg_gate_chk.sv
`timescale 1ns/1ps
module ovmg_gate_chk
   import ovmg_pkg::*;
(
   // clock and reset
   input wire logic               clk,
   input wire logic               srst,
   // configuration
   input wire logic [NUM_MON-1:0] cfg_mon_en,
   input wire logic               cfg_onoff_mapped,
   input wire logic               cfg_mute_en_used,
   input wire logic               cfg_manual_reset,
   // field inputs
   input wire logic               safety_run,
   input wire logic [NUM_MON-1:0] valve_feedback_monitor,
   input wire logic               onoff_cmd,
   input wire logic               mute_enable,
   input wire logic               mute_request,
   input wire logic               reset_in,
   // outputs
   input wire logic               safety_out,
   input wire logic               delay_in_progress,
   input wire logic               onoff_status,
   input wire logic               mute_active,
   input wire logic               lockout
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // unmapped monitors count as satisfied
   wire fb_ok = &(valve_feedback_monitor | ~cfg_mon_en);
   a_lock_holds_off: assert property (lockout |-> !safety_out)
      else $error("output on during lockout");
   a_lock_clear_reset: assert property ($fell(lockout) |-> $past(reset_in) && $past(fb_ok))
      else $error("lockout left without valid reset");
   a_on_needs_run: assert property ($rose(safety_out) |->
      $past(safety_run) && ($past(onoff_cmd) || !$past(cfg_onoff_mapped)))
      else $error("output rose without run or command");
   a_on_needs_feedback: assert property ($rose(safety_out) |-> $past(fb_ok))
      else $error("output rose with feedback low");
   a_manual_holds_off: assert property (
      cfg_manual_reset && !safety_out && !reset_in |=> !safety_out)
      else $error("manual block on without reset");
   a_reset_turns_on: assert property (cfg_manual_reset && reset_in && safety_run && fb_ok
      && !lockout && !safety_out && (onoff_cmd || !cfg_onoff_mapped) |=> safety_out)
      else $error("reset did not turn output on");
   a_mute_gate_off: assert property (cfg_mute_en_used && !mute_enable |=> !mute_active)
      else $error("mute began while not enabled");
   a_mute_level_on: assert property (
      mute_request && (mute_enable || !cfg_mute_en_used) |=> mute_active)
      else $error("enabled mute not taken");
   a_status_follows: assert property (1'b1 |=> onoff_status == $past(onoff_cmd))
      else $error("status does not follow command");
   a_delay_output_on: assert property (delay_in_progress |-> safety_out)
      else $error("delay status with output off");
   cover property ($rose(lockout));
   cover property ($rose(safety_out) && cfg_manual_reset);
   cover property ($rose(mute_active));
   cover property ($rose(delay_in_progress));
endmodule
bind ovmg_gate ovmg_gate_chk ovmg_gate_chk_inst (.*);

// >>> tb/ovmg_field.sv
`timescale 1ns/1ps
module ovmg_field
   import ovmg_pkg::*;
#(
   parameter int LAG = 3
)(
   // clock
   input  wire logic               clk,
   // output under watch and forced faults
   input  wire logic               out_on,
   input  wire logic [NUM_MON-1:0] stuck,
   // contact state
   output logic      [NUM_MON-1:0] feedback
);
   // valve lags the output; contact closes only once de-energised
   logic [LAG-1:0] pipe = '0;
   always_ff @(posedge clk) begin
      pipe <= {pipe[LAG-2:0], out_on};
   end
   // stuck contact never closes, like a welded valve
   assign feedback = ~stuck & {NUM_MON{~pipe[LAG-1]}};
endmodule

// >>> tb/output_valve_monitor_gate_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module output_valve_monitor_gate_test
   import ovmg_pkg::*;
;
   logic [NUM_MON*VMT_SEL_W-1:0] cfg_timeout_sel;
   logic [DLY_W-1:0]             cfg_off_delay_ms;
   logic [NUM_MON-1:0]           cfg_mon_en, valve_feedback_monitor, stuck;
   logic [1:0]                   cfg_cancel_type;
   logic                         clk, srst, cfg_onoff_mapped, cfg_mute_en_used;
   logic                         cfg_manual_reset, safety_run, onoff_cmd, mute_enable;
   logic                         mute_request, reset_in, cancel_delay, safety_out;
   logic                         delay_in_progress, onoff_status, mute_active, lockout;
   int                           mismatches = 0, comparisons = 0, cycles = 0, i;
   integer                       seed = 32'h0DA16ABC;

   ovmg_gate ovmg_gate_inst (.*);
   ovmg_field #(.LAG(3)) ovmg_field_inst (.clk(clk), .out_on(safety_out), .stuck(stuck),
      .feedback(valve_feedback_monitor));

   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic pulse_reset();
      reset_in = 1'h1;
      step(1);
      reset_in = 1'h0;
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   function automatic logic exp_out(logic run, logic cmd, logic mapped);
      return run & (cmd | ~mapped);
   endfunction

   // no test should run near this long
   always @(posedge clk) begin
      cycles++;
      if (cycles > 3000) begin
         mismatches++;
         close_out();
      end
   end

   initial begin
      srst = 1'h1;
      cfg_timeout_sel = 14'h0000;
      cfg_off_delay_ms = 16'h0000;
      cfg_cancel_type = 2'h0;
      cfg_mon_en = 2'h3;
      stuck = 2'h0;
      {cfg_onoff_mapped, cfg_mute_en_used, cfg_manual_reset, safety_run, onoff_cmd,
         mute_enable, mute_request, reset_in, cancel_delay} = 9'h000;
      step(16);
      srst = 1'h0;
      // long enough for the valve to settle between draws
      for (i = 0; i < 60; i++) begin
         {safety_run, onoff_cmd, cfg_onoff_mapped, cfg_mute_en_used, mute_enable,
            mute_request} = 6'($random(seed));
         step(10);
         `CHK(safety_out, exp_out(safety_run, onoff_cmd, cfg_onoff_mapped))
         `CHK(onoff_status, onoff_cmd)
         `CHK(mute_active, mute_request & (mute_enable | ~cfg_mute_en_used))
      end
      $display("test 1 done");
      {safety_run, onoff_cmd} = 2'h3;
      step(10);
      stuck = 2'h2;
      safety_run = 1'h0;
      step(2);
      safety_run = 1'h1;
      step(20);
      `CHK(safety_out, 1'h0)
      `CHK(lockout, 1'h0)
      stuck = 2'h0;
      step(8);
      `CHK(safety_out, 1'h1)
      $display("test 2 done");
      srst = 1'h1;
      cfg_manual_reset = 1'h1;
      cfg_onoff_mapped = 1'h1;
      step(2);
      srst = 1'h0;
      step(5);
      `CHK(safety_out, 1'h0)
      pulse_reset();
      `CHK(safety_out, 1'h1)
      safety_run = 1'h0;
      step(2);
      safety_run = 1'h1;
      step(5);
      `CHK(safety_out, 1'h0)
      stuck = 2'h1;
      step(5);
      pulse_reset();
      step(3);
      `CHK(lockout, 1'h1)
      `CHK(safety_out, 1'h0)
      stuck = 2'h0;
      step(8);
      `CHK(lockout, 1'h1)
      pulse_reset();
      step(2);
      `CHK(lockout, 1'h0)
      pulse_reset();
      `CHK(safety_out, 1'h1)
      $display("test 3 done");
      cfg_manual_reset = 1'h0;
      cfg_off_delay_ms = 16'h0001;
      cfg_cancel_type = 2'h0;
      safety_run = 1'h0;
      step(2);
      `CHK(delay_in_progress, 1'h1)
      `CHK(safety_out, 1'h1)
      cancel_delay = 1'h1;
      step(1);
      `CHK(safety_out, 1'h1)
      `CHK(delay_in_progress, 1'h0)
      cancel_delay = 1'h0;
      cfg_cancel_type = 2'h1;
      step(1);
      cancel_delay = 1'h1;
      step(1);
      `CHK(safety_out, 1'h0)
      cancel_delay = 1'h0;
      cfg_cancel_type = 2'h2;
      safety_run = 1'h1;
      step(10);
      safety_run = 1'h0;
      step(2);
      safety_run = 1'h1;
      step(1);
      `CHK(safety_out, 1'h1)
      `CHK(delay_in_progress, 1'h0)
      $display("test 4 done");
      close_out();
   end
endmodule
